//--- rtl/fcp_pkg.sv
// fcp_pkg: constants, carriers and helpers of the external flag pin control block.
// assumes one clock domain; each instruction cycle is two clock periods.
package fcp_pkg;

	// wishbone register map, byte addresses
	localparam int FCP_ADDR_W = 4;
	localparam logic [FCP_ADDR_W-1:0] FCP_FLAG_IO_OFFSET = 4'h0;
	localparam logic [FCP_ADDR_W-1:0] FCP_STATUS_OFFSET = 4'h4;

	// flag_io_control_register layout, pin n uses base + 4*n
	localparam int FCP_DIR_BIT0 = 1;
	localparam int FCP_OUT_BIT0 = 2;
	localparam int FCP_IN_BIT0 = 3;
	localparam int FCP_PIN_STRIDE = 4;
	localparam logic [7:0] FCP_FLAG_IO_RESET = 8'h00;
	localparam logic [7:0] FCP_FLAG_IO_WR_MASK = 8'h66;
	localparam logic [7:0] FCP_FLAG_IO_RD_MASK = 8'hee;

	// status register layout
	localparam int FCP_ST_BUSY_BIT = 0;
	localparam int FCP_ST_STORE_BIT = 1;
	localparam int FCP_ST_SAMPLE_BIT = 2;

	// pin input synchroniser depth
	localparam int FCP_SYNC_STAGES = 3;

	// interlocked store address width
	localparam int FCP_STORE_ADDR_W = 24;

	// phase counter values: phase_clock_three rise, phase_clock_one fall
	localparam logic FCP_PHASE_THREE = 1'b0;
	localparam logic FCP_PHASE_ONE = 1'b1;

	typedef struct packed {
		logic [1:0] level;
		logic [1:0] oe;
	} fcp_pin_out_t;

	typedef struct packed {
		logic valid;
		logic [FCP_STORE_ADDR_W-1:0] addr;
	} fcp_store_addr_t;

	typedef enum logic [3:0] {
		FCP_IDLE = 4'b0001,
		FCP_DRIVE_LOW = 4'b0010,
		FCP_SAMPLE = 4'b0100,
		FCP_RAISE = 4'b1000
	} fcp_state_t;

	function automatic int fcp_dir_pos(input logic n);
		return FCP_DIR_BIT0 + FCP_PIN_STRIDE * int'(n);
	endfunction : fcp_dir_pos

	function automatic int fcp_out_pos(input logic n);
		return FCP_OUT_BIT0 + FCP_PIN_STRIDE * int'(n);
	endfunction : fcp_out_pos

	function automatic int fcp_in_pos(input logic n);
		return FCP_IN_BIT0 + FCP_PIN_STRIDE * int'(n);
	endfunction : fcp_in_pos

endpackage : fcp_pkg

//--- rtl/fcp_sync3.sv
// fcp_sync3: three-stage synchroniser for asynchronous pin inputs.
// assumes the input may change at any time; output moves only when stages two and three agree.
`timescale 1ns/10ps
module fcp_sync3 #(
	parameter int WIDTH = 2
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_level
);
	import fcp_pkg::*;

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;

	always_comb
	begin
		level_next = level_reg;
		for (int i = 0; i < WIDTH; i++)
		begin
			// first stage is only read by the second
			if (s2_reg[i] == s3_reg[i])
			begin
				level_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
		end
		else
		begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign o_level = level_reg;

endmodule : fcp_sync3

//--- rtl/fcp_flag_ctrl.sv
// fcp_flag_ctrl: two external flag pins with direction, output and input bits,
// interlocked load/store/signal sequencing and a classic wishbone register slave.
// assumes the cpu pipeline gives one-cycle instruction pulses on i_ref_clk and that
// a pad ring resolves the pin from level and oe.
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/10ps

module fcp_flag_ctrl (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// classic wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [fcp_pkg::FCP_ADDR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// cpu pipeline
	input wire logic i_ilock_load,
	input wire logic i_ilock_store,
	input wire logic i_store_stall,
	input wire logic [fcp_pkg::FCP_STORE_ADDR_W-1:0] i_store_addr,
	input wire logic i_ilock_signal,
	output fcp_pkg::fcp_store_addr_t o_store,
	output logic o_ilock_done,
	output logic o_ilock_flag_one,
	output logic o_ilock_busy,
	// flag pins
	input wire logic [1:0] i_flag_pin_n,
	output fcp_pkg::fcp_pin_out_t o_flag_pin_n
);
	import fcp_pkg::*;

	logic phase_reg;
	logic phase_next;
	logic h3_edge;
	logic h1_edge;
	logic [1:0] pin_sync;

	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [1:0] drive_lvl_reg;
	logic [1:0] drive_lvl_next;
	logic [1:0] drive_en_reg;
	logic [1:0] drive_en_next;

	fcp_state_t state_reg;
	fcp_state_t state_next;
	logic is_signal_reg;
	logic is_signal_next;
	logic done_reg;
	logic done_next;
	logic sample_reg;
	logic sample_next;

	logic store_req_reg;
	logic store_req_next;
	logic addr_wait_reg;
	logic addr_wait_next;
	logic [FCP_STORE_ADDR_W-1:0] addr_hold_reg;
	logic [FCP_STORE_ADDR_W-1:0] addr_hold_next;
	fcp_store_addr_t store_reg;
	fcp_store_addr_t store_next;

	logic ack_reg;
	logic ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic wb_req;
	logic wr_ctrl;

	fcp_sync3 #(
		.WIDTH(2)
	) u_pin_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_async(i_flag_pin_n),
		.o_level(pin_sync)
	);

	// two clocks per instruction cycle: one phase three rise, one phase one fall
	always_comb
	begin
		phase_next = ~phase_reg;
		h3_edge = (phase_reg == FCP_PHASE_THREE);
		h1_edge = (phase_reg == FCP_PHASE_ONE);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			phase_reg <= FCP_PHASE_THREE;
		end
		else
		begin
			phase_reg <= phase_next;
		end
	end

	// wishbone decode; answer one cycle after the request
	// a write lands at the edge where the master samples ack, while it still holds the request
	always_comb
	begin
		wb_req = i_wb_cyc & i_wb_stb & ~ack_reg;
		wr_ctrl = i_wb_cyc & i_wb_stb & ack_reg & i_wb_we & i_wb_sel[0]
			& (i_wb_adr == FCP_FLAG_IO_OFFSET);
		ack_next = wb_req;
		rdata_next = rdata_reg;
		if (wb_req & ~i_wb_we)
		begin
			rdata_next = 32'h0000_0000;
			if (i_wb_adr == FCP_FLAG_IO_OFFSET)
			begin
				rdata_next[7:0] = ctrl_reg & FCP_FLAG_IO_RD_MASK;
			end
			else if (i_wb_adr == FCP_STATUS_OFFSET)
			begin
				rdata_next[FCP_ST_BUSY_BIT] = (state_reg != FCP_IDLE);
				rdata_next[FCP_ST_STORE_BIT] = store_req_reg | addr_wait_reg;
				rdata_next[FCP_ST_SAMPLE_BIT] = sample_reg;
			end
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// load / signal interlock sequencer
	always_comb
	begin
		state_next = state_reg;
		is_signal_next = is_signal_reg;
		done_next = 1'b0;
		sample_next = sample_reg;
		case (state_reg)
			FCP_IDLE:
			begin
				if (i_ilock_load | i_ilock_signal)
				begin
					state_next = FCP_DRIVE_LOW;
					is_signal_next = i_ilock_signal;
				end
			end
			FCP_DRIVE_LOW:
			begin
				if (h3_edge)
				begin
					state_next = FCP_SAMPLE;
				end
			end
			FCP_SAMPLE:
			begin
				if (h1_edge)
				begin
					sample_next = pin_sync[1];
					state_next = is_signal_reg ? FCP_RAISE : FCP_IDLE;
					done_next = ~is_signal_reg;
				end
			end
			FCP_RAISE:
			begin
				if (h3_edge)
				begin
					state_next = FCP_IDLE;
					done_next = 1'b1;
				end
			end
			default:
			begin
				state_next = FCP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			state_reg <= FCP_IDLE;
			is_signal_reg <= 1'b0;
			done_reg <= 1'b0;
			sample_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			is_signal_reg <= is_signal_next;
			done_reg <= done_next;
			sample_reg <= sample_next;
		end
	end

	// interlocked store: flag high at execute start, address waits out a stall
	always_comb
	begin
		store_req_next = store_req_reg | i_ilock_store;
		addr_wait_next = addr_wait_reg;
		addr_hold_next = i_ilock_store ? i_store_addr : addr_hold_reg;
		store_next = '0;
		store_next.addr = store_reg.addr;
		if (h3_edge & (store_req_reg | addr_wait_reg))
		begin
			store_req_next = i_ilock_store;
			if (~i_store_stall)
			begin
				store_next.valid = 1'b1;
				store_next.addr = addr_hold_reg;
				addr_wait_next = 1'b0;
			end
			else
			begin
				addr_wait_next = 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			store_req_reg <= 1'b0;
			addr_wait_reg <= 1'b0;
			addr_hold_reg <= '0;
			store_reg <= '0;
		end
		else
		begin
			store_req_reg <= store_req_next;
			addr_wait_reg <= addr_wait_next;
			addr_hold_reg <= addr_hold_next;
			store_reg <= store_next;
		end
	end

	// control register and pin drivers; instruction effects win over a software write
	always_comb
	begin
		ctrl_next = ctrl_reg;
		drive_lvl_next = drive_lvl_reg;
		drive_en_next = drive_en_reg;
		if (wr_ctrl)
		begin
			ctrl_next = (ctrl_reg & ~FCP_FLAG_IO_WR_MASK) | (i_wb_dat[7:0] & FCP_FLAG_IO_WR_MASK);
		end
		for (int n = 0; n < 2; n++)
		begin
			// an input pin is captured once its driver has been released; pin one is also captured in FCP_SAMPLE, driver or not
			if (h1_edge & ~drive_en_reg[n])
			begin
				ctrl_next[fcp_in_pos(n[0])] = pin_sync[n];
			end
		end
		if (state_reg == FCP_SAMPLE && h1_edge)
		begin
			ctrl_next[fcp_in_pos(1'b1)] = pin_sync[1];
		end
		if (h3_edge)
		begin
			if (state_reg == FCP_DRIVE_LOW)
			begin
				ctrl_next[fcp_out_pos(1'b0)] = 1'b0;
			end
			if (state_reg == FCP_RAISE || store_req_reg)
			begin
				ctrl_next[fcp_out_pos(1'b0)] = 1'b1;
			end
		end
		ctrl_next = ctrl_next & FCP_FLAG_IO_RD_MASK;
		if (h3_edge)
		begin
			for (int n = 0; n < 2; n++)
			begin
				// pins change only at the phase three edge, from the register view
				drive_lvl_next[n] = ctrl_next[fcp_out_pos(n[0])];
				drive_en_next[n] = ctrl_next[fcp_dir_pos(n[0])];
			end
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			ctrl_reg <= FCP_FLAG_IO_RESET;
			drive_lvl_reg <= 2'h0;
			drive_en_reg <= 2'h0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			drive_lvl_reg <= drive_lvl_next;
			drive_en_reg <= drive_en_next;
		end
	end

	// reset gates the enables directly, so the pins float without waiting for an edge
	always_comb
	begin
		o_flag_pin_n.level = drive_lvl_reg;
		o_flag_pin_n.oe = drive_en_reg & {2{~i_rst}};
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdata_reg;
	assign o_store = store_reg;
	assign o_ilock_done = done_reg;
	assign o_ilock_flag_one = sample_reg;
	assign o_ilock_busy = (state_reg != FCP_IDLE);

endmodule : fcp_flag_ctrl

//--- test/fcp_flag_ctrl_props.sv
// fcp_flag_ctrl_props: port-level checks of the flag pin control block.
// assumes one clock and a wishbone master that holds its request until ack.
`timescale 1ns/10ps
module fcp_flag_ctrl_props
	import fcp_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_wb_we,
	input wire logic [fcp_pkg::FCP_ADDR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic i_ilock_load,
	input wire logic i_ilock_store,
	input wire logic i_store_stall,
	input wire logic i_ilock_signal,
	input wire fcp_pkg::fcp_store_addr_t o_store,
	input wire logic o_ilock_done,
	input wire logic o_ilock_busy,
	input wire fcp_pkg::fcp_pin_out_t o_flag_pin_n
);
	logic wr_hit;
	logic [7:0] wr_reg;
	logic [7:0] wr_next;
	// request is still held at the ack edge, where the write lands
	assign wr_hit = o_wb_ack && i_wb_we && i_wb_adr == FCP_FLAG_IO_OFFSET && i_wb_sel[0];
	always_comb
	begin
		wr_next = wr_hit ? i_wb_dat[7:0] : wr_reg;
	end
	always_ff @(posedge i_ref_clk)
	begin
		wr_reg <= i_rst ? 8'h00 : wr_next;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence s_flag0_pulse;
		!o_flag_pin_n.level[0] ##[1:4] o_flag_pin_n.level[0];
	endsequence
	sequence s_store_free;
		i_ilock_store && !i_store_stall ##1 !i_store_stall [*2];
	endsequence
	a_oe_reset:
		assert property (disable iff (1'b0) i_rst |-> o_flag_pin_n.oe == 2'b00)
		else $error("pins driven in reset");
	a_dir_follow:
		assert property (wr_hit |-> ##[1:2] o_flag_pin_n.oe == {wr_reg[5], wr_reg[1]})
		else $error("pin direction mismatch");
	a_level_follow:
		assert property (wr_hit |-> ##[1:2] (o_flag_pin_n.level & o_flag_pin_n.oe)
			== ({wr_reg[6], wr_reg[2]} & {wr_reg[5], wr_reg[1]}))
		else $error("pin level mismatch");
	a_rd_reserved:
		assert property (o_wb_ack && !i_wb_we && i_wb_adr == FCP_FLAG_IO_OFFSET
			|-> (o_wb_dat & 32'hffffff11) == 32'h0)
		else $error("reserved bits set");
	a_store_raise:
		assert property (i_ilock_store && o_flag_pin_n.oe[0] |-> ##[1:3] o_flag_pin_n.level[0])
		else $error("store left pin low");
	a_store_wait:
		assert property (o_store.valid |-> !$past(i_store_stall))
		else $error("address out during stall");
	a_store_go:
		assert property (s_store_free |-> ##[0:1] (o_store.valid || $past(o_store.valid)))
		else $error("address late");
	a_load_done:
		assert property (i_ilock_load && !o_ilock_busy |-> ##[1:5] o_ilock_done)
		else $error("load never done");
	a_load_low:
		assert property (i_ilock_load && !o_ilock_busy && o_flag_pin_n.oe[0]
			|-> ##[1:3] !o_flag_pin_n.level[0])
		else $error("load left pin high");
	a_signal_pulse:
		assert property (i_ilock_signal && !o_ilock_busy && o_flag_pin_n.oe[0]
			|-> ##[1:3] s_flag0_pulse)
		else $error("signal pulse wrong");
endmodule : fcp_flag_ctrl_props
bind fcp_flag_ctrl fcp_flag_ctrl_props fcp_flag_ctrl_props_i (.i_ref_clk, .i_rst, .i_wb_we,
	.i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_ilock_load, .i_ilock_store,
	.i_store_stall, .i_ilock_signal, .o_store, .o_ilock_done, .o_ilock_busy, .o_flag_pin_n);

//--- test/fcp_flag_partner.sv
// fcp_flag_partner: external logic facing the two flag pins.
// assumes it drives a pin whenever the device does not; resolves both pin levels.
`timescale 1ns/10ps
module fcp_flag_partner
	import fcp_pkg::*;
(
	input wire logic i_ref_clk,
	input wire fcp_pkg::fcp_pin_out_t i_dev,
	input wire logic [1:0] i_ext,
	input wire logic i_echo,
	input wire logic [2:0] i_lag,
	output logic [1:0] o_pin
);
	logic [7:0] hist_reg;
	always_ff @(posedge i_ref_clk)
	begin
		hist_reg <= {hist_reg[6:0], o_pin[0]};
	end
	assign o_pin[0] = i_dev.oe[0] ? i_dev.level[0] : i_ext[0];
	// echo answers flag pin zero after i_lag plus one cycles, prompt or slow
	assign o_pin[1] = i_dev.oe[1] ? i_dev.level[1] : (i_echo ? hist_reg[i_lag] : i_ext[1]);
endmodule : fcp_flag_partner

//--- test/fcp_flag_ctrl_tb.sv
// fcp_flag_ctrl_tb: random and corner stimulus for the flag pin control block.
// assumes the partner model and the checker are compiled before it.
`timescale 1ns/10ps
module fcp_flag_ctrl_tb;
	import fcp_pkg::*;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ld = 0, st = 0, stall = 0, sg = 0;
	logic echo = 0;
	logic [3:0] adr = 0, sel = 0;
	logic [31:0] wdat = 0, rdat, o_dat;
	logic [23:0] sadr = 0;
	logic [1:0] ext = 0, pin;
	logic [2:0] lag = 0;
	logic [7:0] w;
	logic ack, done, flag1, busy, sv;
	fcp_store_addr_t store;
	fcp_pin_out_t pout;
	int n_errors = 0, samples_checked = 0, cyc_cnt = 0, seed = 32'h4fc0, k;
	always #10 clk = ~clk;
	assign sv = store.valid;
	fcp_flag_ctrl fcp_flag_ctrl_i (.i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_dat),
		.o_wb_ack(ack), .i_ilock_load(ld), .i_ilock_store(st), .i_store_stall(stall),
		.i_store_addr(sadr), .i_ilock_signal(sg), .o_store(store), .o_ilock_done(done),
		.o_ilock_flag_one(flag1), .o_ilock_busy(busy), .i_flag_pin_n(pin), .o_flag_pin_n(pout));
	fcp_flag_partner fcp_flag_partner_i (.i_ref_clk(clk), .i_dev(pout), .i_ext(ext),
		.i_echo(echo), .i_lag(lag), .o_pin(pin));
	function automatic logic [31:0] exp_in(input logic [1:0] e);
		return {24'h0, e[1], 3'h0, e[0], 3'h0};
	endfunction : exp_in
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, wr, a, d, s};
		do @(posedge clk); while (ack !== 1'b1);
		rdat = o_dat;
		{cyc, stb} <= 2'b00;
	endtask : wb
	task automatic await(input logic use_sv);
		k = 0;
		while ((use_sv ? sv : done) !== 1'b1 && k < 12)
		begin
			@(posedge clk);
			k++;
		end
		chk(k < 12, 1);
	endtask : await
	task automatic fire(input logic is_sig);
		@(posedge clk);
		if (is_sig)
			sg <= 1'b1;
		else
			ld <= 1'b1;
		@(posedge clk);
		{ld, sg} <= 2'b00;
		await(1'b0);
	endtask : fire
	task automatic close_out;
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	always @(posedge clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 3000)
		begin
			n_errors++;
			close_out();
		end
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (6)
		begin
			w = 8'($random(seed));
			wb(1, 0, {24'($random(seed)), w}, 4'h1);
			repeat (3) @(posedge clk);
			chk({pout.oe, pout.level & pout.oe}, {w[5], w[1], w[6] & w[5], w[2] & w[1]});
			wb(0, 0, 0, 4'h1);
			chk(rdat & 32'hffffff77, w & 8'h66);
		end
		wb(1, 0, {24'h0, ~w}, 4'h0);
		wb(0, 0, 0, 4'h1);
		chk(rdat & 32'h66, w & 8'h66);
		wb(0, 4'hc, 0, 4'h1);
		chk(rdat, 0);
		$display("register test done");
		repeat (4)
		begin
			wb(1, 0, 32'h66, 4'h1);
			ext <= 2'($random(seed));
			wb(1, 0, 32'h00, 4'h1);
			repeat (8) @(posedge clk);
			wb(0, 0, 0, 4'h1);
			chk(rdat, exp_in(ext));
		end
		$display("input test done");
		wb(1, 0, 32'h06, 4'h1);
		repeat (6) @(posedge clk);
		fire(1'b0);
		chk(flag1, ext[1]);
		chk(pout.level[0], 0);
		echo <= 1'b1;
		for (int j = 0; j < 8; j += 7)
		begin
			lag <= 3'(j);
			fire(1'b1);
			repeat (2) @(posedge clk);
			chk(pout.level[0], 1);
		end
		$display("interlock test done");
		wb(1, 0, 32'h02, 4'h1);
		@(posedge clk);
		sadr <= 24'($random(seed));
		{st, stall} <= 2'b11;
		@(posedge clk);
		st <= 1'b0;
		wb(0, FCP_STATUS_OFFSET, 0, 4'h1);
		chk(rdat[FCP_ST_STORE_BIT], 1);
		chk(rdat[FCP_ST_BUSY_BIT], 0);
		repeat (4) @(posedge clk) chk(sv, 0);
		stall <= 1'b0;
		await(1'b1);
		chk(store.addr, sadr);
		repeat (2) @(posedge clk);
		chk(pout.level[0], 1);
		{st, sadr} <= {1'b1, 24'($random(seed))};
		@(posedge clk);
		st <= 1'b0;
		await(1'b1);
		chk(store.addr, sadr);
		$display("store test done");
		wb(1, 0, 32'h66, 4'h1);
		repeat (3) @(posedge clk);
		rst <= 1'b1;
		#1 chk(pout.oe, 0);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wb(0, 0, 0, 4'h1);
		chk(rdat & 32'h66, FCP_FLAG_IO_RESET & 8'h66);
		chk(pout.oe, 0);
		$display("reset test done");
		close_out();
	end
endmodule : fcp_flag_ctrl_tb
